// File: logic/pas_seq.v
// pan association sequencer with apb register file
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "pas_consts.vh"
module pas_seq #(
    parameter [23:0] TICK_CYC = `PAS_TICK_US * `PAS_CLK_MHZ,
    // arbitrary serial number words
    parameter [31:0] SER_LO = 32'h0000_0001,
    parameter [31:0] SER_HI = 32'h0000_0002
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire beacon_valid,
    input wire [15:0] beacon_pan,
    input wire [7:0] beacon_lqi,
    input wire energy_valid,
    input wire [7:0] energy_level,
    input wire join_req_valid,
    input wire join_confirm,
    input wire rx_unicast,
    input wire [63:0] rx_src,
    input wire ack_rcvd,
    output reg tx_req_q,
    output reg [2:0] tx_kind_q,
    output reg [63:0] tx_dst_q,
    output reg [15:0] tx_dst_pan_q,
    output reg [63:0] tx_src_q,
    output reg tx_src_long_q,
    output reg [3:0] radio_chan_q,
    output reg mac_reset_q,
    output reg sleep_req_q,
    output reg led_q
);
localparam S_IDLE = 4'h0, S_ATX = 4'h1, S_ALIS = 4'h2, S_PPAN = 4'h3;
localparam S_ELIS = 4'h4, S_PCH = 4'h5, S_CRUN = 4'h6, S_EPICK = 4'h7;
localparam S_JTX = 4'h8, S_JWAIT = 4'h9, S_ERUN = 4'ha, S_SLEEP = 4'hb;
localparam D_IDLE = 2'h0, D_PEND = 2'h1, D_WAIT = 2'h2;
// ---
// registers
// ---
reg coord_q, start_q;
reg [2:0] ccfg_q, ecfg_q, slp_q;
reg [15:0] pan_q, short_q, dwell_q;
reg [3:0] chan_q;
reg [31:0] dlo_q, dhi_q;
reg [3:0] st_q, sidx_q, best_q, jind_q;
reg [15:0] cnt_q;
reg [2:0] npan_q;
reg [15:0] lpan [0:4];
reg [3:0] lch [0:4];
reg [7:0] llq [0:4];
reg [7:0] emax [0:15];
reg [7:0] bestv_q;
reg bestok_q, ascan_q, rego_q;
reg [23:0] tick_cnt_q;
reg tick_q;
reg [9:0] led_cnt_q;
reg seq_p_q, ack_p_q, conf_p_q;
reg [2:0] seq_k_q;
reg [15:0] seq_pan_q;
reg [63:0] ack_dst_q;
reg [1:0] dst_q, rtry_q;
reg [7:0] dcnt_q;
reg ack_fail_q;
reg [31:0] rd_d;
reg err_d;
integer i;
wire wr = psel & penable & pwrite & pready;
wire go = rego_q;
wire started = (st_q == S_CRUN);
wire assoc = (st_q == S_ERUN);
wire [15:0] dwell = (dwell_q == 16'h0000) ? 16'h0001 : dwell_q;
wire dwell_end = tick_q & (cnt_q + 16'h0001 >= dwell);
wire bcast_dst = (dhi_q == 32'h0) & (dlo_q == {16'h0000, `PAS_BCAST});
// ---
// helper functions
// ---
function in_list;
    input [15:0] p;
    integer k;
    begin
        in_list = 1'b0;
        for (k = 0; k < 5; k = k + 1) begin
            if ((k < npan_q) && (lpan[k] == p)) in_list = 1'b1;
        end
    end
endfunction
function occupied;
    input [3:0] c;
    integer k;
    begin
        occupied = 1'b0;
        for (k = 0; k < 5; k = k + 1) begin
            if ((k < npan_q) && (lch[k] == c)) occupied = 1'b1;
        end
    end
endfunction
// ---
// configuration change detect
// ---
wire c_chg = wr & (((paddr == `PAS_A_CCFG) & (pwdata[1:0] != ccfg_q[1:0])) |
    ((paddr == `PAS_A_PAN) & (pwdata[15:0] != pan_q)) |
    ((paddr == `PAS_A_CHAN) & (pwdata[3:0] != chan_q)) |
    ((paddr == `PAS_A_SHORT) & (pwdata[15:0] != short_q)));
wire e_chg = wr & (((paddr == `PAS_A_ECFG) & (pwdata[2:0] != ecfg_q)) |
    ((paddr == `PAS_A_PAN) & (pwdata[15:0] != pan_q)) |
    ((paddr == `PAS_A_CHAN) & (pwdata[3:0] != chan_q)));
// ---
// end device candidate pick
// ---
reg cand_ok;
reg [2:0] cand_i;
reg [7:0] cand_lq;
always @* begin
    cand_ok = 1'b0;
    cand_i = 3'h0;
    cand_lq = 8'h00;
    for (i = 0; i < 5; i = i + 1) begin
        if ((i < npan_q) && (ecfg_q[`PAS_B_PANRS] || lpan[i] == pan_q) &&
            (ecfg_q[`PAS_B_CHRS] || lch[i] == chan_q) &&
            (!cand_ok || llq[i] > cand_lq)) begin
            cand_ok = 1'b1;
            cand_i = i[2:0];
            cand_lq = llq[i];
        end
    end
end
wire ch_ok = !(ascan_q && occupied(sidx_q));
wire ch_sel = ch_ok && (!bestok_q || emax[sidx_q] < bestv_q);
// ---
// apb read decode
// ---
always @* begin
    rd_d = 32'h0;
    err_d = 1'b0;
    if (paddr == `PAS_A_ROLE) rd_d = {31'h0, coord_q};
    else if (paddr == `PAS_A_CCFG) rd_d = {29'h0, ccfg_q};
    else if (paddr == `PAS_A_ECFG) rd_d = {29'h0, ecfg_q};
    else if (paddr == `PAS_A_PAN) rd_d = {16'h0, pan_q};
    else if (paddr == `PAS_A_CHAN) rd_d = {28'h0, chan_q};
    else if (paddr == `PAS_A_SHORT) rd_d = {16'h0, short_q};
    else if (paddr == `PAS_A_SLO) rd_d = SER_LO;
    else if (paddr == `PAS_A_SHI) rd_d = SER_HI;
    else if (paddr == `PAS_A_DLO) rd_d = dlo_q;
    else if (paddr == `PAS_A_DHI) rd_d = dhi_q;
    else if (paddr == `PAS_A_DWELL) rd_d = {16'h0, dwell_q};
    else if (paddr == `PAS_A_SLEEP) rd_d = {29'h0, slp_q};
    else if (paddr == `PAS_A_STAT)
        rd_d = {23'h0, ack_fail_q, (dst_q != D_IDLE), npan_q, st_q};
    else if (paddr == `PAS_A_JIND) rd_d = {28'h0, jind_q};
    else if (paddr == `PAS_A_TXC) rd_d = 32'h0;
    else err_d = 1'b1;
end
// ---
// apb slave and config registers
// ---
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0;
        coord_q <= 1'b0;
        ccfg_q <= 3'h0;
        ecfg_q <= 3'h0;
        slp_q <= 3'h0;
        short_q <= `PAS_R_SHORT;
        dwell_q <= `PAS_R_DWELL;
        dlo_q <= 32'h0;
        dhi_q <= 32'h0;
    end else begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & err_d;
        if (psel & ~penable) prdata <= pwrite ? 32'h0 : rd_d;
        if (wr) begin
            if (paddr == `PAS_A_ROLE) coord_q <= pwdata[0];
            else if (paddr == `PAS_A_CCFG) ccfg_q <= pwdata[2:0];
            else if (paddr == `PAS_A_ECFG) ecfg_q <= pwdata[2:0];
            else if (paddr == `PAS_A_SHORT) short_q <= pwdata[15:0];
            else if (paddr == `PAS_A_DLO) dlo_q <= pwdata;
            else if (paddr == `PAS_A_DHI) dhi_q <= pwdata;
            else if (paddr == `PAS_A_DWELL) dwell_q <= pwdata[15:0];
            else if (paddr == `PAS_A_SLEEP) slp_q <= pwdata[2:0];
        end
    end
end
// ---
// millisecond tick and indicator
// ---
wire [9:0] led_half = started ? `PAS_LED_COORD_MS :
    (ecfg_q[`PAS_B_JOIN] ? `PAS_LED_ASSOC_MS : `PAS_LED_MANUAL_MS);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt_q <= 24'h0;
        tick_q <= 1'b0;
        led_cnt_q <= 10'h000;
        led_q <= 1'b1;
    end else begin
        tick_q <= (tick_cnt_q == TICK_CYC - 24'h1);
        tick_cnt_q <= (tick_cnt_q == TICK_CYC - 24'h1) ? 24'h0 : tick_cnt_q + 24'h1;
        if (!(started || assoc)) begin
            led_cnt_q <= 10'h000;
            led_q <= 1'b1;
        end else if (tick_q) begin
            if (led_cnt_q + 10'h001 >= led_half) begin
                led_cnt_q <= 10'h000;
                led_q <= ~led_q;
            end else begin
                led_cnt_q <= led_cnt_q + 10'h001;
            end
        end
    end
end
// ---
// start-up sequencer
// ---
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_q <= S_IDLE;
        sidx_q <= 4'h0;
        cnt_q <= 16'h0000;
        npan_q <= 3'h0;
        best_q <= 4'h0;
        bestv_q <= 8'h00;
        bestok_q <= 1'b0;
        ascan_q <= 1'b0;
        rego_q <= 1'b0;
        pan_q <= `PAS_R_PAN;
        chan_q <= `PAS_R_CHAN;
        jind_q <= `PAS_JI_IDLE;
        seq_p_q <= 1'b0;
        seq_k_q <= `PAS_K_BREQ;
        seq_pan_q <= `PAS_BCAST;
        mac_reset_q <= 1'b0;
        sleep_req_q <= 1'b0;
        for (i = 0; i < 5; i = i + 1) begin
            lpan[i] <= 16'h0000;
            lch[i] <= 4'h0;
            llq[i] <= 8'h00;
        end
        for (i = 0; i < 16; i = i + 1) emax[i] <= 8'h00;
    end else begin
        rego_q <= wr & (paddr == `PAS_A_ROLE) & pwdata[`PAS_B_START];
        mac_reset_q <= 1'b0;
        if (seq_p_q & ~ack_p_q & ~conf_p_q) seq_p_q <= 1'b0;
        if (wr & (paddr == `PAS_A_PAN)) pan_q <= pwdata[15:0];
        if (wr & (paddr == `PAS_A_CHAN)) chan_q <= pwdata[3:0];
        if (tick_q) cnt_q <= cnt_q + 16'h0001;
        if (started & c_chg) mac_reset_q <= 1'b1;
        if (assoc & e_chg) begin
            mac_reset_q <= 1'b1;
            st_q <= S_IDLE;
            rego_q <= 1'b1;
        end else begin
            case (st_q)
            S_IDLE, S_SLEEP: begin
                if (go) begin
                    sleep_req_q <= 1'b0;
                    sidx_q <= 4'h0;
                    cnt_q <= 16'h0000;
                    npan_q <= 3'h0;
                    bestok_q <= 1'b0;
                    ascan_q <= 1'b0;
                    for (i = 0; i < 16; i = i + 1) emax[i] <= 8'h00;
                    if (coord_q) begin
                        jind_q <= `PAS_JI_SCAN;
                        if (ccfg_q[`PAS_B_PANRS]) st_q <= S_ATX;
                        else if (ccfg_q[`PAS_B_CHRS]) st_q <= S_ELIS;
                        else st_q <= S_CRUN;
                    end else if (ecfg_q[`PAS_B_JOIN]) begin
                        jind_q <= `PAS_JI_SCAN;
                        st_q <= S_ATX;
                    end else begin
                        jind_q <= `PAS_JI_OK;
                        st_q <= S_ERUN;
                    end
                end
            end
            S_ATX: begin
                seq_p_q <= 1'b1;
                seq_k_q <= `PAS_K_BREQ;
                seq_pan_q <= `PAS_BCAST;
                ascan_q <= 1'b1;
                cnt_q <= 16'h0000;
                st_q <= S_ALIS;
            end
            S_ALIS: begin
                if (beacon_valid && npan_q < `PAS_MAX_PAN && !in_list(beacon_pan)) begin
                    lpan[npan_q] <= beacon_pan;
                    lch[npan_q] <= sidx_q;
                    llq[npan_q] <= beacon_lqi;
                    npan_q <= npan_q + 3'h1;
                end
                if (npan_q == `PAS_MAX_PAN || (dwell_end && sidx_q == `PAS_LAST_CH)) begin
                    st_q <= coord_q ? S_PPAN : S_EPICK;
                end else if (dwell_end) begin
                    sidx_q <= sidx_q + 4'h1;
                    st_q <= S_ATX;
                end
            end
            S_PPAN: begin
                if (in_list(pan_q) || pan_q == `PAS_BCAST || pan_q == `PAS_RSVD) begin
                    pan_q <= pan_q + 16'h0001;
                end else if (ccfg_q[`PAS_B_CHRS]) begin
                    sidx_q <= 4'h0;
                    cnt_q <= 16'h0000;
                    st_q <= S_ELIS;
                end else begin
                    st_q <= S_CRUN;
                end
            end
            S_ELIS: begin
                if (energy_valid && radio_chan_q == sidx_q && energy_level > emax[sidx_q])
                    emax[sidx_q] <= energy_level;
                if (dwell_end) begin
                    cnt_q <= 16'h0000;
                    sidx_q <= (sidx_q == `PAS_LAST_CH) ? 4'h0 : sidx_q + 4'h1;
                    if (sidx_q == `PAS_LAST_CH) st_q <= S_PCH;
                end
            end
            S_PCH: begin
                if (ch_sel) begin
                    best_q <= sidx_q;
                    bestv_q <= emax[sidx_q];
                    bestok_q <= 1'b1;
                end
                if (sidx_q == `PAS_LAST_CH) begin
                    if (ch_sel) chan_q <= sidx_q;
                    else if (bestok_q) chan_q <= best_q;
                    st_q <= S_CRUN;
                end else begin
                    sidx_q <= sidx_q + 4'h1;
                end
            end
            S_CRUN: begin
                jind_q <= `PAS_JI_OK;
            end
            S_EPICK: begin
                if (cand_ok) begin
                    pan_q <= lpan[cand_i];
                    chan_q <= lch[cand_i];
                    st_q <= S_JTX;
                end else begin
                    jind_q <= `PAS_JI_NOCOORD;
                    if (slp_q != 3'h0) begin
                        sleep_req_q <= 1'b1;
                        st_q <= S_SLEEP;
                    end else begin
                        st_q <= S_IDLE;
                        rego_q <= 1'b1;
                    end
                end
            end
            S_JTX: begin
                seq_p_q <= 1'b1;
                seq_k_q <= `PAS_K_AREQ;
                seq_pan_q <= pan_q;
                cnt_q <= 16'h0000;
                st_q <= S_JWAIT;
            end
            S_JWAIT: begin
                if (join_confirm) begin
                    jind_q <= `PAS_JI_OK;
                    st_q <= S_ERUN;
                end else if (tick_q && cnt_q + 16'h0001 >= `PAS_ASSOC_WAIT_MS) begin
                    jind_q <= `PAS_JI_TIMEOUT;
                    st_q <= S_IDLE;
                    rego_q <= 1'b1;
                end
            end
            default: ;
            endcase
        end
    end
end
// ---
// transmit arbitration, ack and retry
// ---
wire free_dat = ~ack_p_q & ~conf_p_q & ~seq_p_q;
wire src_long = (short_q == `PAS_BCAST) || (short_q == `PAS_RSVD);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_req_q <= 1'b0;
        tx_kind_q <= `PAS_K_DATA;
        tx_dst_q <= 64'h0;
        tx_dst_pan_q <= 16'h0000;
        tx_src_q <= 64'h0;
        tx_src_long_q <= 1'b0;
        radio_chan_q <= `PAS_R_CHAN;
        ack_p_q <= 1'b0;
        conf_p_q <= 1'b0;
        ack_dst_q <= 64'h0;
        dst_q <= D_IDLE;
        rtry_q <= 2'h0;
        dcnt_q <= 8'h00;
        ack_fail_q <= 1'b0;
    end else begin
        tx_req_q <= 1'b0;
        radio_chan_q <= (st_q == S_ATX || st_q == S_ALIS || st_q == S_ELIS) ?
            sidx_q : chan_q;
        tx_src_long_q <= src_long;
        tx_src_q <= src_long ? {SER_HI, SER_LO} : {48'h0, short_q};
        if (rx_unicast) begin
            ack_p_q <= 1'b1;
            ack_dst_q <= rx_src;
        end else if (ack_p_q) begin
            ack_p_q <= 1'b0;
        end
        if (join_req_valid && started && ccfg_q[`PAS_B_JOIN]) conf_p_q <= 1'b1;
        else if (conf_p_q && !ack_p_q) conf_p_q <= 1'b0;
        if (ack_p_q) begin
            tx_req_q <= 1'b1;
            tx_kind_q <= `PAS_K_ACK;
            tx_dst_q <= ack_dst_q;
            tx_dst_pan_q <= pan_q;
        end else if (conf_p_q) begin
            tx_req_q <= 1'b1;
            tx_kind_q <= `PAS_K_ACONF;
            tx_dst_q <= {48'h0, `PAS_BCAST};
            tx_dst_pan_q <= pan_q;
        end else if (seq_p_q) begin
            tx_req_q <= 1'b1;
            tx_kind_q <= seq_k_q;
            tx_dst_q <= {48'h0, `PAS_BCAST};
            tx_dst_pan_q <= seq_pan_q;
        end else if (dst_q == D_PEND) begin
            tx_req_q <= 1'b1;
            tx_kind_q <= `PAS_K_DATA;
            tx_dst_q <= {dhi_q, dlo_q};
            tx_dst_pan_q <= pan_q;
        end
        case (dst_q)
        D_IDLE: begin
            if (wr && paddr == `PAS_A_TXC && pwdata[0]) begin
                dst_q <= D_PEND;
                rtry_q <= 2'h0;
                ack_fail_q <= 1'b0;
            end
        end
        D_PEND: begin
            if (free_dat) begin
                dcnt_q <= 8'h00;
                dst_q <= bcast_dst ? D_IDLE : D_WAIT;
            end
        end
        D_WAIT: begin
            if (tick_q) dcnt_q <= dcnt_q + 8'h01;
            if (ack_rcvd) begin
                dst_q <= D_IDLE;
            end else if (tick_q && dcnt_q + 8'h01 >= `PAS_ACK_WAIT_MS) begin
                if (rtry_q < `PAS_RETRIES) begin
                    rtry_q <= rtry_q + 2'h1;
                    dst_q <= D_PEND;
                end else begin
                    ack_fail_q <= 1'b1;
                    dst_q <= D_IDLE;
                end
            end
        end
        default: dst_q <= D_IDLE;
        endcase
    end
end
endmodule // pas_seq

// File: pkg/pas_consts.vh
// constants for the pan association sequencer
// What this block does
// - coordinator pan reselect runs active beacon scan
// - active scan ends after all channels or five
// - keep pan id unless detected, else pick free
// - pan reselect clear: no scan, keep pan
// - channel reselect runs energy scan, keep maxima
// - pick quietest channel, excluding occupied channels
// - channel reselect clear: keep configured channel
// - start coordinator; admit joiners only when allowed
// - coordinator indicator blinks 1/s, solid before start
// - key setting change resets mac only
// - end device auto join: discover then associate
// - no auto join: use config, blink 5/s
// - end device active scan with beacon requests
// - pan reselect clear keeps only matching pan
// - channel reselect clear keeps only own channel
// - pick strongest link; none: sleep or retry
// - request association, wait confirm, blink 2/s
// - config change disassociates, resets mac, restarts
// - reserved short address selects 64-bit source
// - unicast ack received packets, up to three resends
// - coordinator select picks coordinator role
`ifndef PAS_CONSTS_VH
`define PAS_CONSTS_VH
`define PAS_A_ROLE 8'h00
`define PAS_A_CCFG 8'h04
`define PAS_A_ECFG 8'h08
`define PAS_A_PAN 8'h0c
`define PAS_A_CHAN 8'h10
`define PAS_A_SHORT 8'h14
`define PAS_A_SLO 8'h18
`define PAS_A_SHI 8'h1c
`define PAS_A_DLO 8'h20
`define PAS_A_DHI 8'h24
`define PAS_A_DWELL 8'h28
`define PAS_A_SLEEP 8'h2c
`define PAS_A_STAT 8'h30
`define PAS_A_JIND 8'h34
`define PAS_A_TXC 8'h38
`define PAS_B_PANRS 0
`define PAS_B_CHRS 1
`define PAS_B_JOIN 2
`define PAS_B_START 1
`define PAS_R_PAN 16'h0000
`define PAS_R_CHAN 4'h0
`define PAS_R_SHORT 16'h0000
`define PAS_R_DWELL 16'h0004
`define PAS_LAST_CH 4'hf
`define PAS_MAX_PAN 3'h5
`define PAS_BCAST 16'hffff
`define PAS_RSVD 16'hfffe
`define PAS_RETRIES 2'h3
`define PAS_CLK_MHZ 100
`define PAS_TICK_US 1000
`define PAS_LED_COORD_MS 10'h1f4
`define PAS_LED_ASSOC_MS 10'h0fa
`define PAS_LED_MANUAL_MS 10'h064
`define PAS_ASSOC_WAIT_MS 16'h01f4
`define PAS_ACK_WAIT_MS 8'h02
`define PAS_K_DATA 3'h0
`define PAS_K_ACK 3'h1
`define PAS_K_BREQ 3'h2
`define PAS_K_AREQ 3'h3
`define PAS_K_ACONF 3'h4
`define PAS_JI_OK 4'h0
`define PAS_JI_SCAN 4'h1
`define PAS_JI_NOCOORD 4'h2
`define PAS_JI_TIMEOUT 4'h3
`define PAS_JI_IDLE 4'hf
`endif

// File: tb/pas_props.sv
// checker for the sequencer
`timescale 1ns/10ps
`include "pas_consts.vh"
module pas_props #(
    parameter [31:0] SER_LO = 32'h0000_0001,
    parameter [31:0] SER_HI = 32'h0000_0002
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rx_unicast,
    input wire [63:0] rx_src,
    input wire tx_req_q,
    input wire [2:0] tx_kind_q,
    input wire [63:0] tx_dst_q,
    input wire [15:0] tx_dst_pan_q,
    input wire [63:0] tx_src_q,
    input wire tx_src_long_q,
    input wire [3:0] radio_chan_q,
    input wire mac_reset_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [3:0] last_q;
    wire breq = tx_req_q && tx_kind_q == `PAS_K_BREQ;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) last_q <= 4'hf;
        else if (breq) last_q <= radio_chan_q;
    end
    AST_BREQ_DST: assert property (breq |->
        tx_dst_q[15:0] == `PAS_BCAST && tx_dst_pan_q == `PAS_BCAST) else $error("bad scan dest");
    AST_SCAN_ORDER: assert property (breq |->
        radio_chan_q == 4'h0 || radio_chan_q == last_q + 4'h1) else $error("scan order");
    AST_SRC_LONG: assert property (tx_src_long_q |->
        tx_src_q == {SER_HI, SER_LO}) else $error("long source");
    AST_SRC_SHORT: assert property (!tx_src_long_q |->
        tx_src_q[63:16] == 48'h0 && tx_src_q[15:0] < `PAS_RSVD) else $error("short source");
    AST_ACK: assert property (rx_unicast |-> ##2 tx_req_q &&
        tx_kind_q == `PAS_K_ACK && tx_dst_q == $past(rx_src, 2)) else $error("no ack");
    AST_MAC_PULSE: assert property (mac_reset_q |=> !mac_reset_q) else $error("mac pulse");
    AST_AREQ_DST: assert property (tx_req_q && tx_kind_q == `PAS_K_AREQ |->
        tx_dst_q[15:0] == `PAS_BCAST) else $error("join dest");
    AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0) else $error("slverr");
    COV_BREQ: cover property (breq);
    COV_AREQ: cover property (tx_req_q && tx_kind_q == `PAS_K_AREQ);
    COV_MAC: cover property (mac_reset_q);
endmodule // pas_props
bind pas_seq pas_props #(.SER_LO(SER_LO), .SER_HI(SER_HI)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_unicast(rx_unicast), .rx_src(rx_src), .tx_req_q(tx_req_q),
    .tx_kind_q(tx_kind_q), .tx_dst_q(tx_dst_q), .tx_dst_pan_q(tx_dst_pan_q),
    .tx_src_q(tx_src_q), .tx_src_long_q(tx_src_long_q), .radio_chan_q(radio_chan_q),
    .mac_reset_q(mac_reset_q));

// File: tb/pas_peer.sv
// far radio model
`timescale 1ns/10ps
`include "pas_consts.vh"
module pas_peer (
    input wire pclk,
    input wire presetn,
    input wire tx_req_q,
    input wire [2:0] tx_kind_q,
    input wire [3:0] radio_chan_q,
    input wire ack_en,
    output reg beacon_valid,
    output reg [15:0] beacon_pan,
    output reg [7:0] beacon_lqi,
    output reg energy_valid,
    output reg [7:0] energy_level,
    output reg join_confirm,
    output reg ack_rcvd
);
    wire c3 = radio_chan_q == 4'h3;
    wire hit = tx_req_q && tx_kind_q == `PAS_K_BREQ && (c3 || radio_chan_q == 4'h7);
    always @* energy_level = c3 ? 8'h01 : (radio_chan_q == 4'h9 ? 8'h02 : {4'h8, radio_chan_q});
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {beacon_valid, energy_valid, join_confirm, ack_rcvd} <= 4'h0;
            beacon_pan <= 16'h0000;
            beacon_lqi <= 8'h00;
        end else begin
            beacon_valid <= hit;
            beacon_pan <= hit ? (c3 ? 16'h0005 : 16'h0007) : ~beacon_pan;
            beacon_lqi <= hit ? 8'h40 : ~beacon_lqi;
            energy_valid <= 1'b1;
            join_confirm <= tx_req_q && tx_kind_q == `PAS_K_AREQ;
            ack_rcvd <= ack_en && tx_req_q && tx_kind_q == `PAS_K_DATA;
        end
    end
endmodule // pas_peer

// File: tb/pan_association_sequencer_tb.sv
// bench for the sequencer
`timescale 1ns/10ps
`include "pas_consts.vh"
module pan_association_sequencer_tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg join_req_valid = 0, rx_unicast = 0, ack_en = 0, er;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg [63:0] rx_src = 64'h0;
    wire [31:0] prdata;
    wire pready, pslverr, bv, ev, jc, ar, tx_req_q, tx_src_long_q, mac_reset_q, led_q;
    wire [15:0] bp, tx_dst_pan_q;
    wire [7:0] bl, el;
    wire [2:0] tx_kind_q;
    wire [63:0] tx_dst_q, tx_src_q;
    wire [3:0] radio_chan_q;
    integer fail_count = 0, comparisons = 0, seed = 47, macs = 0, ntx = 0, ncf = 0, i, m, k;
    always #5 pclk = ~pclk;
    always @(negedge pclk) begin
        if (mac_reset_q === 1'b1) macs = macs + 1;
        if (tx_req_q === 1'b1 && tx_kind_q === `PAS_K_DATA) ntx = ntx + 1;
        if (tx_req_q === 1'b1 && tx_kind_q === `PAS_K_ACONF) ncf = ncf + 1;
    end
    pas_seq #(.TICK_CYC(24'd10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .beacon_valid(bv), .beacon_pan(bp),
        .beacon_lqi(bl), .energy_valid(ev), .energy_level(el), .join_req_valid(join_req_valid),
        .join_confirm(jc), .rx_unicast(rx_unicast), .rx_src(rx_src), .ack_rcvd(ar),
        .tx_req_q(tx_req_q), .tx_kind_q(tx_kind_q), .tx_dst_q(tx_dst_q),
        .tx_dst_pan_q(tx_dst_pan_q), .tx_src_q(tx_src_q), .tx_src_long_q(tx_src_long_q),
        .radio_chan_q(radio_chan_q), .mac_reset_q(mac_reset_q), .sleep_req_q(), .led_q(led_q));
    pas_peer u_peer (.pclk(pclk), .presetn(presetn), .tx_req_q(tx_req_q), .tx_kind_q(tx_kind_q),
        .radio_chan_q(radio_chan_q), .ack_en(ack_en), .beacon_valid(bv), .beacon_pan(bp),
        .beacon_lqi(bl), .energy_valid(ev), .energy_level(el), .join_confirm(jc), .ack_rcvd(ar));
    task wrap_up;
        begin
            $display("comparisons %0d fail_count %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string nm, input [63:0] got, input [63:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk) penable <= 1'b1;
            n = 0;
            do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 50);
            if (n >= 50) begin chk("pready", pready, 1); wrap_up; end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask
    task rchk(input string nm, input [7:0] a, input [31:0] e);
        begin apb(0, a, 0); chk(nm, rd, e); end
    endtask
    task wait_st(input [3:0] s);
        integer n;
        begin
            n = 0;
            do begin apb(0, `PAS_A_STAT, 0); n = n + 1; end while (rd[3:0] !== s && n < 3000);
            if (n >= 3000) begin chk("state", rd[3:0], s); wrap_up; end
        end
    endtask
    task led_per(input integer e);
        integer n;
        reg l;
        begin
            repeat (2) begin
                n = 0;
                @(negedge pclk); l = led_q;
                while (led_q === l && n < 30000) begin @(negedge pclk); n = n + 1; end
            end
            chk("led period", n + 1, e);
        end
    endtask
    task wt(input integer n); repeat (n) @(negedge pclk); endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk("pan reset", `PAS_A_PAN, 32'h0);
        rchk("dwell reset", `PAS_A_DWELL, 32'h4);
        apb(1, `PAS_A_SLO, 32'hffff_ffff);
        rchk("serial lo", `PAS_A_SLO, 32'h1);
        apb(0, 8'h3c, 0);
        chk("unmapped", {er, rd}, 64'h1_0000_0000);
        for (i = 0; i < 4; i = i + 1) begin
            m = (i < 2) ? 32'hfffe + i : $random(seed) & 32'hfff0;
            apb(1, `PAS_A_SHORT, m); wt(2);
            chk("src long", tx_src_long_q, i < 2);
            chk("src", tx_src_q, i < 2 ? 64'h2_0000_0001 : m);
        end
        $display("address test done");
        apb(1, `PAS_A_DWELL, 1); apb(1, `PAS_A_PAN, 5); apb(1, `PAS_A_CHAN, 2);
        apb(1, `PAS_A_CCFG, 3); apb(1, `PAS_A_ROLE, 3);
        wait_st(4'h6);
        rchk("pan", `PAS_A_PAN, 32'h6);
        rchk("chan", `PAS_A_CHAN, 32'h9);
        led_per(5000);
        m = macs;
        for (i = 0; i < 2; i = i + 1) begin
            apb(1, `PAS_A_CCFG, i ? 3 : 7);
            k = ncf;
            @(posedge pclk) join_req_valid <= 1'b1;
            @(posedge pclk) join_req_valid <= 1'b0;
            wt(8); chk("confirms", ncf - k, 1 - i);
        end
        chk("mac resets", macs - m, 0);
        apb(1, `PAS_A_PAN, 8); wt(4);
        chk("mac resets", macs - m, 1);
        @(posedge pclk) begin rx_unicast <= 1'b1; rx_src <= {$random(seed), $random(seed)}; end
        @(posedge pclk) rx_unicast <= 1'b0;
        apb(1, `PAS_A_DLO, 32'h12); apb(1, `PAS_A_DHI, 0);
        for (i = 0; i < 2; i = i + 1) begin
            ack_en <= i;
            m = ntx;
            apb(1, `PAS_A_TXC, 1); wt(200);
            chk("data sends", ntx - m, i ? 1 : 4);
            if (i == 0) begin apb(0, `PAS_A_STAT, 0); chk("ack fail", rd[8], 1); end
        end
        $display("coordinator test done");
        presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        apb(1, `PAS_A_ECFG, 0); apb(1, `PAS_A_PAN, 7); apb(1, `PAS_A_CHAN, 7);
        apb(1, `PAS_A_ROLE, 2);
        wait_st(4'ha);
        led_per(1000);
        m = macs;
        apb(1, `PAS_A_ECFG, 4); wt(4);
        chk("restart", macs - m, 1);
        wait_st(4'h2);
        wait_st(4'ha);
        rchk("join ind", `PAS_A_JIND, 32'h0);
        led_per(2500);
        $display("end device test done");
        wrap_up;
    end
endmodule // pan_association_sequencer_tb
